/* rtl/elc_top.sv */
// embedded logic capture core: bus registers, trigger sequencer and trace buffer
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`include "elc_regs.svh"
module elc_top import elc_pkg::*; #(
  parameter int              MON_W        = 8,
  parameter int              DEPTH        = 1024,
  parameter int              STAGES       = 3,
  parameter int              STIM_W       = 8,
  parameter bit              STARTUP_EN   = 1'b0,
  parameter logic [MON_W-1:0] STARTUP_CARE = '0,
  parameter logic [MON_W-1:0] STARTUP_VAL  = '0,
  parameter logic [MON_W-1:0] STARTUP_EDGE = '0,
  parameter bit              STARTUP_AND  = 1'b1,
  parameter logic [1:0]      STARTUP_PRE  = 2'h0
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              cap_clk,
  input  wire logic [MON_W-1:0]  monitor,
  output logic      [STIM_W-1:0] stimulus,
  output logic                   stimulus_valid
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef struct packed {
    logic                          waitreq;
    logic [31:0]                   rdata;
    logic [1:0]                    pre;
    logic [1:0]                    last;
    logic [STAGES-1:0]             and_sel;
    logic [STIM_W-1:0]             stim;
    logic [STAGES-1:0][MON_W-1:0]  care;
    logic [STAGES-1:0][MON_W-1:0]  val;
    logic [STAGES-1:0][MON_W-1:0]  edg;
    logic                          busy;
    logic                          done;
    logic                          cxl;
    logic                          arm_tgl;
    logic                          cxl_tgl;
    logic                          done_seen;
    logic [AW-1:0]                 idx;
  } elc_bus_t;

  typedef struct packed {
    elc_cap_state_t    st;
    logic              arm_seen;
    logic              cxl_seen;
    logic              done_tgl;
    logic              su_pending;
    logic              su_mode;
    logic [1:0]        stage;
    logic [MON_W-1:0]  prev;
    logic [AW-1:0]     wptr;
    logic [AW-1:0]     trig_addr;
    logic [AW-1:0]     start_addr;
    logic [AW:0]       fill;
    logic [AW:0]       post;
    logic [STIM_W-1:0] stim;
    logic              stim_valid;
  } elc_cap_t;

  elc_bus_t         b;
  elc_bus_t         next_b;
  elc_cap_t         c;
  elc_cap_t         next_c;
  logic [MON_W-1:0] mem [DEPTH];
  logic [1:0]       cap_tgl_s;
  logic             done_s;
  logic             arm_ev;
  logic             cxl_ev;
  logic             ev;
  logic             match;
  logic             wr_en;
  logic [1:0]       last_sel;
  logic [1:0]       pre_sel;
  logic [AW:0]      pre_cnt;
  logic [AW:0]      post_len;
  logic [MON_W-1:0] sel_care;
  logic [MON_W-1:0] sel_val;
  logic [MON_W-1:0] sel_edg;
  logic             sel_and;
  logic [3:0]       sidx;
  logic             stg_hit;
  logic             bus_req;
  logic             bus_ack;

  // ----------------------------------------
  // crossings
  // ----------------------------------------
  // config words are only written while idle, so the cap side reads them stable
  elc_sync #(.W(2)) u_cap_sync (
    .clk   (cap_clk),
    .reset (reset),
    .d     ({b.cxl_tgl, b.arm_tgl}),
    .q     (cap_tgl_s)
  );

  elc_sync #(.W(1)) u_bus_sync (
    .clk   (clk),
    .reset (reset),
    .d     (c.done_tgl),
    .q     (done_s)
  );

  // ----------------------------------------
  // bus side registers
  // ----------------------------------------
  assign bus_req = avs_read | avs_write;
  assign bus_ack = bus_req & ~b.waitreq;
  assign sidx    = avs_address[7:4] - `ELC_STG_BASE;
  assign stg_hit = (avs_address[7:4] >= `ELC_STG_BASE) && (32'(sidx) < STAGES)
                   && (avs_address[3:2] != 2'h3) && (avs_address[1:0] == 2'h0);

  always_comb begin
    next_b = b;
    next_b.waitreq = 1'b1;
    // one wait state, then a single-cycle answer
    if (bus_req && b.waitreq) begin
      next_b.waitreq = 1'b0;
      next_b.rdata   = 32'h0;
      unique case (avs_address)
        `ELC_CTRL_OFS: begin
          next_b.rdata[`ELC_CTRL_PRE +: 2]      = b.pre;
          next_b.rdata[`ELC_CTRL_LAST +: 2]     = b.last;
          next_b.rdata[`ELC_CTRL_AND +: STAGES] = b.and_sel;
        end
        `ELC_STAT_OFS: begin
          next_b.rdata[`ELC_STAT_BUSY] = b.busy;
          next_b.rdata[`ELC_STAT_DONE] = b.done;
          next_b.rdata[`ELC_STAT_CXL]  = b.cxl;
          next_b.rdata[`ELC_STAT_SU]   = c.su_mode;
        end
        `ELC_START_OFS: next_b.rdata = 32'(c.start_addr);
        `ELC_TRIG_OFS:  next_b.rdata = 32'(c.trig_addr);
        `ELC_STIM_OFS:  next_b.rdata = 32'(b.stim);
        `ELC_IDX_OFS:   next_b.rdata = 32'(b.idx);
        `ELC_DATA_OFS:  next_b.rdata = 32'(mem[c.start_addr + b.idx]);
        default: begin
          if (stg_hit) begin
            unique case (avs_address[3:2])
              `ELC_STG_CARE: next_b.rdata = 32'(b.care[sidx[1:0]]);
              `ELC_STG_VAL:  next_b.rdata = 32'(b.val[sidx[1:0]]);
              default:       next_b.rdata = 32'(b.edg[sidx[1:0]]);
            endcase
          end
        end
      endcase
    end
    if (done_s != b.done_seen) begin
      next_b.done_seen = done_s;
      if (b.busy) begin
        next_b.busy = 1'b0;
        next_b.done = 1'b1;
      end
    end
    if (avs_write && bus_ack) begin
      if (avs_address == `ELC_DATA_OFS - 8'h04) begin
        next_b.idx = avs_writedata[AW-1:0];
      end
      if (avs_address == `ELC_CTRL_OFS) begin
        if (!b.busy) begin
          next_b.pre     = avs_writedata[`ELC_CTRL_PRE +: 2];
          next_b.last    = avs_writedata[`ELC_CTRL_LAST +: 2];
          next_b.and_sel = avs_writedata[`ELC_CTRL_AND +: STAGES];
        end
        if (avs_writedata[`ELC_CTRL_CXL] && b.busy) begin
          next_b.busy    = 1'b0;
          next_b.cxl     = 1'b1;
          next_b.cxl_tgl = ~b.cxl_tgl;
        end
        if (avs_writedata[`ELC_CTRL_ARM]) begin
          next_b.busy    = 1'b1;
          next_b.done    = 1'b0;
          next_b.cxl     = 1'b0;
          next_b.arm_tgl = ~b.arm_tgl;
        end
      end else if (!b.busy) begin
        if (avs_address == `ELC_STIM_OFS) begin
          next_b.stim = avs_writedata[STIM_W-1:0];
        end
        if (stg_hit) begin
          unique case (avs_address[3:2])
            `ELC_STG_CARE: next_b.care[sidx[1:0]] = avs_writedata[MON_W-1:0];
            `ELC_STG_VAL:  next_b.val[sidx[1:0]]  = avs_writedata[MON_W-1:0];
            default:       next_b.edg[sidx[1:0]]  = avs_writedata[MON_W-1:0];
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      b         <= '0;
      b.waitreq <= 1'b1;
      b.pre     <= `ELC_PRE_RST;
      b.last    <= `ELC_LAST_RST;
      b.and_sel <= '1;
      b.busy    <= STARTUP_EN;
    end else begin
      b <= next_b;
    end
  end

  assign avs_readdata    = b.rdata;
  assign avs_waitrequest = b.waitreq;

  // ----------------------------------------
  // capture side
  // ----------------------------------------
  // startup capture uses its build-time pattern as a single stage
  assign sel_care = c.su_mode ? STARTUP_CARE : b.care[c.stage];
  assign sel_val  = c.su_mode ? STARTUP_VAL : b.val[c.stage];
  assign sel_edg  = c.su_mode ? STARTUP_EDGE : b.edg[c.stage];
  assign sel_and  = c.su_mode ? STARTUP_AND : b.and_sel[c.stage];
  assign last_sel = c.su_mode ? 2'h0 : b.last;
  assign pre_sel  = c.su_mode ? STARTUP_PRE : b.pre;
  assign pre_cnt  = (AW+1)'((DEPTH / `ELC_PRE_STEPS) * int'(pre_sel));
  assign post_len = (AW+1)'(DEPTH) - pre_cnt - (AW+1)'(1);

  elc_trig_stage #(.W(MON_W)) u_stage (
    .cur     (monitor),
    .prev    (c.prev),
    .care    (sel_care),
    .val     (sel_val),
    .edg     (sel_edg),
    .and_sel (sel_and),
    .match   (match)
  );

  assign arm_ev = cap_tgl_s[0] != c.arm_seen;
  assign cxl_ev = cap_tgl_s[1] != c.cxl_seen;
  assign wr_en  = (c.st == ELC_RUN) || (c.st == ELC_POST);
  assign ev     = (c.st == ELC_RUN) && (c.fill >= pre_cnt);

  always_comb begin
    next_c = c;
    next_c.prev = monitor;
    unique case (c.st)
      ELC_IDLE: begin
        if (c.su_pending) begin
          next_c.st         = ELC_RUN;
          next_c.su_mode    = 1'b1;
          next_c.su_pending = 1'b0;
          next_c.fill       = '0;
          next_c.stage      = 2'h0;
        end
      end
      ELC_RUN: begin
        next_c.wptr = c.wptr + 1'b1;
        if (c.fill < pre_cnt) begin
          next_c.fill = c.fill + 1'b1;
        end
        if (ev && match) begin
          if (c.stage == last_sel) begin
            next_c.trig_addr  = c.wptr;
            next_c.start_addr = c.wptr - pre_cnt[AW-1:0];
            next_c.post       = post_len;
            next_c.st         = ELC_POST;
          end else begin
            next_c.stage = c.stage + 2'h1;
          end
        end
      end
      ELC_POST: begin
        next_c.wptr = c.wptr + 1'b1;
        next_c.post = c.post - 1'b1;
        if (c.post == (AW+1)'(1)) begin
          next_c.st         = ELC_DONE;
          next_c.done_tgl   = ~c.done_tgl;
          next_c.stim_valid = 1'b0;
        end
      end
      ELC_DONE: begin
        next_c.st = ELC_DONE;
      end
    endcase
    if (cxl_ev) begin
      next_c.cxl_seen   = cap_tgl_s[1];
      next_c.st         = ELC_IDLE;
      next_c.stim_valid = 1'b0;
      next_c.su_pending = 1'b0;
      next_c.su_mode    = 1'b0;
    end
    // arm drops startup and old trace
    if (arm_ev) begin
      next_c.arm_seen   = cap_tgl_s[0];
      next_c.st         = ELC_RUN;
      next_c.su_mode    = 1'b0;
      next_c.su_pending = 1'b0;
      next_c.fill       = '0;
      next_c.stage      = 2'h0;
      next_c.stim       = b.stim;
      next_c.stim_valid = 1'b1;
    end
  end

  // nothing here stalls or resets the user design
  always_ff @(posedge cap_clk or posedge reset) begin
    if (reset) begin
      c            <= '0;
      c.st         <= ELC_IDLE;
      c.su_pending <= STARTUP_EN;
    end else begin
      c <= next_c;
    end
  end

  always_ff @(posedge cap_clk) begin
    if (wr_en) begin
      mem[c.wptr] <= monitor;
    end
  end

  assign stimulus       = c.stim;
  assign stimulus_valid = c.stim_valid;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [AW:0] h_after;

  always_ff @(posedge cap_clk or posedge reset) begin
    if (reset) begin
      h_after <= '0;
    end else if (c.st == ELC_RUN) begin
      h_after <= (AW+1)'(1);
    end else if (c.st == ELC_POST) begin
      h_after <= h_after + 1'b1;
    end
  end

  sequence s_fire;
    ev && match && (c.stage == last_sel) && !arm_ev && !cxl_ev;
  endsequence

  sequence s_quiet;
    !arm_ev && !cxl_ev;
  endsequence

  post_count_a: assert property (@(posedge cap_clk) disable iff (reset)
    (c.st == ELC_POST) && (next_c.st == ELC_DONE) |=> h_after == (AW+1)'(DEPTH) - pre_cnt)
    else $error("post-trigger sample count wrong");

  pre_window_a: assert property (@(posedge cap_clk) disable iff (reset)
    s_fire |=> (c.st == ELC_POST) && (AW'(c.trig_addr - c.start_addr) == $past(pre_cnt)))
    else $error("pre-trigger window misplaced");

  and_miss_a: assert property (@(posedge cap_clk) disable iff (reset)
    (ev && sel_and && ((((monitor ^ sel_val) & sel_care & ~sel_edg)) != '0)) and s_quiet
    |=> (c.st == ELC_RUN) && $stable(c.stage))
    else $error("AND stage advanced on mismatch");

  or_hit_a: assert property (@(posedge cap_clk) disable iff (reset)
    (ev && !sel_and && (((~(monitor ^ sel_val)) & sel_care & ~sel_edg) != '0)) and s_quiet
    |=> (c.st == ELC_POST) || (c.stage != $past(c.stage)))
    else $error("OR stage missed a matching channel");

  all_x_a: assert property (@(posedge cap_clk) disable iff (reset)
    (ev && (sel_care == '0)) and s_quiet |=> (c.st == ELC_POST) || (c.stage != $past(c.stage)))
    else $error("all don't-care stage did not match");

  arm_clear_a: assert property (@(posedge cap_clk) disable iff (reset)
    arm_ev |=> (c.st == ELC_RUN) && (c.fill == '0) && !c.su_mode && !c.su_pending && c.stim_valid)
    else $error("arm did not restart capture");

  startup_once_a: assert property (@(posedge cap_clk) disable iff (reset)
    c.su_pending |=> !c.su_pending ##1 !c.su_pending)
    else $error("startup capture offered twice");

  stim_hold_a: assert property (@(posedge cap_clk) disable iff (reset)
    stimulus_valid && $past(stimulus_valid) && !$past(arm_ev) |-> $stable(stimulus))
    else $error("stimulus changed while valid");

  done_freeze_a: assert property (@(posedge cap_clk) disable iff (reset)
    (c.st == ELC_DONE) and s_quiet |=> $stable(c.wptr) && (c.st == ELC_DONE))
    else $error("buffer written after capture ended");

  arm_busy_a: assert property (@(posedge clk) disable iff (reset)
    avs_write && bus_ack && (avs_address == `ELC_CTRL_OFS) && avs_writedata[`ELC_CTRL_ARM]
    |=> b.busy && !b.done ##1 b.busy)
    else $error("arm write did not start a session");

  bus_answer_a: assert property (@(posedge clk) disable iff (reset)
    bus_req && b.waitreq |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule

/* rtl/elc_regs.svh */
// register offsets, field positions and reset values of the embedded logic capture core
`ifndef ELC_REGS_SVH
`define ELC_REGS_SVH

// ----------------------------------------
// register byte offsets, stage block base (address[7:4]) and stage word selects (address[3:2])
// ----------------------------------------
`define ELC_CTRL_OFS   8'h00
`define ELC_STAT_OFS   8'h04
`define ELC_START_OFS  8'h08
`define ELC_STIM_OFS   8'h0C
`define ELC_IDX_OFS    8'h10
`define ELC_DATA_OFS   8'h14
`define ELC_TRIG_OFS   8'h18
`define ELC_STG_BASE   4'h2
`define ELC_STG_CARE   2'h0
`define ELC_STG_VAL    2'h1
`define ELC_STG_EDGE   2'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define ELC_CTRL_ARM   0
`define ELC_CTRL_CXL   1
`define ELC_CTRL_PRE   2
`define ELC_CTRL_LAST  4
`define ELC_CTRL_AND   8
`define ELC_STAT_BUSY  0
`define ELC_STAT_DONE  1
`define ELC_STAT_CXL   2
`define ELC_STAT_SU    3

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define ELC_PRE_RST    2'h0
`define ELC_LAST_RST   2'h0
`define ELC_PRE_STEPS  4

`endif

/* rtl/elc_pkg.sv */
// types shared by the embedded logic capture core
package elc_pkg;
  typedef enum logic [3:0] {
    ELC_IDLE = 4'b0001,
    ELC_RUN  = 4'b0010,
    ELC_POST = 4'b0100,
    ELC_DONE = 4'b1000
  } elc_cap_state_t;
endpackage

/* rtl/elc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module elc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* rtl/elc_trig_stage.sv */
// pattern match of one trigger stage
`timescale 1ns/10ps
module elc_trig_stage #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] cur,
  input  wire logic [W-1:0] prev,
  input  wire logic [W-1:0] care,
  input  wire logic [W-1:0] val,
  input  wire logic [W-1:0] edg,
  input  wire logic         and_sel,
  output logic              match
);
  logic [W-1:0] hit;

  assign hit = (edg & ((val & cur & ~prev) | (~val & ~cur & prev))) | (~edg & ~(cur ^ val));
  assign match = (care == '0) | (and_sel ? ((hit & care) == care) : |(hit & care));
endmodule

/* verif/elc_user_model.sv */
// free-running user design model that feeds the monitored bus and takes the stimulus
`timescale 1ns/10ps
module elc_user_model (
  input  wire logic       cap_clk,
  input  wire logic       reset,
  input  wire logic [7:0] stimulus,
  input  wire logic       stimulus_valid,
  output logic      [7:0] monitor,
  output logic      [7:0] stim_seen,
  output logic      [7:0] sessions,
  output logic      [7:0] arm_mon
);
  logic vld_q;

  // ----------------------------------------
  // user logic
  // ----------------------------------------
  // a plain counter makes every captured sample predictable
  always_ff @(posedge cap_clk or posedge reset) begin
    if (reset) begin
      monitor   <= 8'h00;
      stim_seen <= 8'h00;
      sessions  <= 8'h00;
      arm_mon   <= 8'h00;
      vld_q     <= 1'b0;
    end else begin
      monitor <= monitor + 8'h01;
      vld_q   <= stimulus_valid;
      if (stimulus_valid) begin
        stim_seen <= stimulus;
      end
      if (stimulus_valid && !vld_q) begin
        sessions <= sessions + 8'h01;
        // first sample the core stores after this arm
        arm_mon  <= monitor;
      end
    end
  end
endmodule

/* verif/tb_embedded_logic_capture.sv */
// self-checking bench of the embedded logic capture core
`timescale 1ns/10ps
`include "elc_regs.svh"
module tb_embedded_logic_capture;
  // small depth keeps the readback short
  localparam int DEPTH = 16;
  localparam int Q     = DEPTH / 4;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest;
  logic        cap_clk, stimulus_valid;
  logic [7:0]  avs_address, monitor, stimulus, stim_seen, sessions, arm_mon;
  logic [31:0] avs_writedata, avs_readdata, rd, d0;
  int          miscompares, checked, n;

  // startup pattern waits for the counter to reach 30 with a quarter pre window
  elc_top #(.DEPTH(DEPTH), .STARTUP_EN(1'b1), .STARTUP_CARE(8'hFF), .STARTUP_VAL(8'h30),
            .STARTUP_PRE(2'h1)) DUT (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_clk(cap_clk), .monitor(monitor),
    .stimulus(stimulus), .stimulus_valid(stimulus_valid));

  elc_user_model partner (
    .cap_clk(cap_clk), .reset(reset), .stimulus(stimulus), .stimulus_valid(stimulus_valid),
    .monitor(monitor), .stim_seen(stim_seen), .sessions(sessions), .arm_mon(arm_mon));

  // ----------------------------------------
  // clocks
  // ----------------------------------------
  always #50 clk = ~clk;
  initial begin
    cap_clk = 1'b0;
    #3;
    forever #7.5 cap_clk = ~cap_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic lapse();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) lapse();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic stg(input logic [7:0] s, input logic [7:0] care, val, edg);
    bus(1'b1, 8'h20 + 8'h10 * s, {24'h0, care});
    bus(1'b1, 8'h24 + 8'h10 * s, {24'h0, val});
    bus(1'b1, 8'h28 + 8'h10 * s, {24'h0, edg});
  endtask

  // wait for a capture to end, then read the buffer back oldest first
  task automatic collect(input logic [1:0] pre, input logic [7:0] exp, msk);
    logic [31:0] st;
    int          k;
    k = 0;
    do begin
      bus(1'b0, `ELC_STAT_OFS, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 300);
    if (rd[1] !== 1'b1) lapse();
    bus(1'b0, `ELC_START_OFS, 32'h0);
    st = rd;
    // the core stores the trigger sample at this address
    rc(`ELC_TRIG_OFS, DEPTH - 1, (st + pre * Q) & (DEPTH - 1));
    for (int i = 0; i < DEPTH; i++) begin
      bus(1'b1, `ELC_IDX_OFS, i);
      bus(1'b0, `ELC_DATA_OFS, 32'h0);
      if (i == 0) d0 = rd;
      chk(rd, (d0 + i) & 32'hFF);
      if (i == pre * Q) chk(rd & {24'h0, msk}, {24'h0, exp & msk});
    end
  endtask

  // one arm, capture and readback session
  task automatic run(input logic [1:0] pre, last, input logic [2:0] andm,
                     input logic [7:0] stim, exp, msk);
    logic [31:0] cfg;
    logic [7:0]  ses0;
    cfg  = {21'h0, andm, 2'b00, last, pre, 2'b00};
    ses0 = sessions;
    bus(1'b1, `ELC_CTRL_OFS, cfg);
    bus(1'b1, `ELC_STIM_OFS, {24'h0, stim});
    bus(1'b1, `ELC_CTRL_OFS, cfg | 32'h1);
    rc(`ELC_STAT_OFS, 32'hB, 32'h1);
    collect(pre, exp, msk);
    chk({31'h0, stimulus_valid}, 32'h0);
    chk({24'h0, stim_seen}, {24'h0, stim});
    chk({24'h0, sessions}, {24'h0, ses0 + 8'h01});
    // an all don't-care stage fires as soon as the pre window is full
    if (msk == 8'h00) chk(d0, {24'h0, arm_mon});
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    clk           = 1'b0;
    reset         = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 8'h00;
    avs_writedata = 32'h0;
    miscompares   = 0;
    checked       = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rc(`ELC_CTRL_OFS, 32'h7FC, 32'h700);
    rc(`ELC_STIM_OFS, 32'hFFFFFFFF, 32'h0);
    rc(8'hFC, 32'hFFFFFFFF, 32'h0);
    // startup capture runs from reset with no arm
    collect(2'd1, 8'h30, 8'hFF);
    rc(`ELC_STAT_OFS, 32'hFFFFFFFF, 32'hA);
    chk({31'h0, stimulus_valid}, 32'h0);
    chk({24'h0, sessions}, 32'h0);
    stg(8'h0, 8'hFF, 8'h40, 8'h00);
    run(2'd1, 2'd0, 3'b111, 8'hA5, 8'h40, 8'hFF);
    // middle stage OR on two channels, last stage a rising edge
    stg(8'h0, 8'hFF, 8'h10, 8'h00);
    stg(8'h1, 8'h81, 8'h81, 8'h00);
    stg(8'h2, 8'h20, 8'h20, 8'h20);
    run(2'd2, 2'd2, 3'b101, 8'h3C, 8'h20, 8'hFF);
    stg(8'h0, 8'h10, 8'h00, 8'h10);
    stg(8'h1, 8'h03, 8'h02, 8'h00);
    run(2'd0, 2'd1, 3'b111, 8'h5A, 8'h02, 8'h1F);
    // contradictory edges never match, so only a cancel ends it
    stg(8'h0, 8'h03, 8'h01, 8'h03);
    bus(1'b1, `ELC_CTRL_OFS, 32'h705);
    n = 0;
    while (stimulus_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (stimulus_valid !== 1'b1) lapse();
    rc(`ELC_STAT_OFS, 32'hF, 32'h1);
    bus(1'b1, `ELC_CTRL_OFS, 32'h70C);
    rc(`ELC_CTRL_OFS, 32'h7FC, 32'h704);
    bus(1'b1, `ELC_CTRL_OFS, 32'h706);
    rc(`ELC_STAT_OFS, 32'h7, 32'h4);
    n = 0;
    while (stimulus_valid !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, stimulus_valid}, 32'h0);
    // repeated records of an all don't-care stage
    stg(8'h0, 8'h00, 8'h00, 8'h00);
    repeat (2) run(2'd3, 2'd0, 3'b000, 8'hC3, 8'h00, 8'h00);
    print_verdict();
  end
endmodule
